// File: common/usq_cfg.svh
// Purpose: Offsets, field positions, reset values for the sequencer.
// Assumes: Included by the package and the design modules.
// Notes: Definitions only.
`ifndef USQ_CFG_SVH
`define USQ_CFG_SVH

// Widths
`define USQ_AW 8
`define USQ_CW 16
`define USQ_OPW 4
`define USQ_STW 4
`define USQ_ROM_DEPTH 256

// APB byte offsets
`define USQ_OFS_CTRL 8'h00
`define USQ_OFS_STATUS 8'h04
`define USQ_OFS_ROM_PTR 8'h08
`define USQ_OFS_ROM_DATA 8'h0C
`define USQ_OFS_PIPE 8'h10
`define USQ_OFS_BREAK 8'h14
`define USQ_OFS_COND 8'h18

// Control register bits
`define USQ_CTRL_RUN 0
`define USQ_CTRL_STEP 1
`define USQ_CTRL_BRK_EN 2

// Status register fields
`define USQ_ST_ADDR_LSB 0
`define USQ_ST_RET_LSB 8
`define USQ_ST_RUN 16
`define USQ_ST_HIT 17

// Microword field positions
`define USQ_MW_JUMP_LSB 0
`define USQ_MW_SEL_LSB 8
`define USQ_MW_CJ 10
`define USQ_MW_CSEL_LSB 11
`define USQ_MW_CTRL_LSB 16

// Reset values
`define USQ_RST_ADDR 8'h00
`define USQ_RST_WORD 32'h0000_0000
`define USQ_RST_CTRL 16'h0000

`endif

// File: common/usq_pkg.sv
// Purpose: Types shared by the sequencer modules.
// Assumes: usq_cfg.svh holds the address, control, opcode and status widths.
// Notes: Source select codes follow the microword encoding.
`include "usq_cfg.svh"

package usq_pkg;
   typedef logic [`USQ_AW-1:0] usq_addr_t;
   typedef logic [`USQ_CW-1:0] usq_ctrl_t;
   typedef logic [`USQ_OPW-1:0] usq_op_t;
   typedef logic [`USQ_STW-1:0] usq_status_t;
   typedef logic [31:0] usq_word_t;

   typedef enum logic [1:0] {
      USQ_SRC_OPCODE = 2'b00,
      USQ_SRC_JUMP = 2'b01,
      USQ_SRC_RETURN = 2'b10,
      USQ_SRC_CONTINUE_SEQUENTIAL = 2'b11
   } usq_src_t;
endpackage

// File: common/usq_seq_if.sv
// Purpose: Carries microword fields and address sources between modules.
// Assumes: One clock; all signals combinational inside a cycle.
// Notes: core drives fields, exec decides, mux builds the address.
interface usq_seq_if;
   import usq_pkg::*;
   usq_src_t src_sel;
   logic cond_jump;
   logic [1:0] cond_sel;
   usq_addr_t jump_addr;
   usq_status_t alu_status;
   usq_op_t opcode;
   usq_addr_t addr_q;
   usq_addr_t ret_q;
   usq_src_t eff_sel;
   logic cond_value;
   logic call_taken;
   usq_addr_t incr;
   usq_addr_t next_addr;

   modport core (
      output src_sel, cond_jump, cond_sel, jump_addr, alu_status,
      output opcode, addr_q, ret_q,
      input eff_sel, cond_value, call_taken, incr, next_addr
   );
   modport exec (
      input src_sel, cond_jump, cond_sel, alu_status,
      output eff_sel, cond_value, call_taken
   );
   modport mux (
      input eff_sel, jump_addr, opcode, addr_q, ret_q,
      output incr, next_addr
   );
endinterface

// File: src/usq_exec.sv
// Purpose: Condition select and execution logic of the sequencer.
// Assumes: Status lines are on the sequencer clock already.
// Notes: Purely combinational.
module usq_exec (
   usq_seq_if.exec seq
);
   import usq_pkg::*;

   always_comb begin
      seq.cond_value = seq.alu_status[seq.cond_sel];
      seq.eff_sel = seq.src_sel;
      if (seq.cond_jump && !seq.cond_value) begin
         seq.eff_sel = USQ_SRC_CONTINUE_SEQUENTIAL;
      end
      seq.call_taken = (seq.eff_sel == USQ_SRC_JUMP);
   end
endmodule

// File: src/usq_addr_mux.sv
// Purpose: Next microaddress source multiplexer with incrementer.
// Assumes: addr_q is the address register of the running word.
// Notes: Wraps from the top of the store to address zero.
`include "usq_cfg.svh"

module usq_addr_mux (
   usq_seq_if.mux seq
);
   import usq_pkg::*;

   usq_addr_t entry;

   always_comb begin
      seq.incr = usq_addr_t'(seq.addr_q + usq_addr_t'(1));
      entry = {seq.opcode, {(`USQ_AW-`USQ_OPW){1'b0}}};
      unique case (seq.eff_sel)
         USQ_SRC_OPCODE: seq.next_addr = entry;
         USQ_SRC_JUMP: seq.next_addr = seq.jump_addr;
         USQ_SRC_RETURN: seq.next_addr = seq.ret_q;
         USQ_SRC_CONTINUE_SEQUENTIAL: seq.next_addr = seq.incr;
      endcase
   end
endmodule

// File: src/usq_top.sv
// Purpose: Microprogram address sequencer with control store over APB.
// Assumes: Opcode and ALU status come from logic on pclk.
// Notes: APB answers with one wait state; offsets live in usq_cfg.svh.
//
// How it works
// - Select 00 takes the next address from the opcode entry point.
// - Select 01 takes the next address from the jump address field.
// - Select 10 returns through the saved return register.
// - Select 11 continues with the microprogram counter.
// - A call saves the address register plus one as return address.
// - The entry point is the opcode on top and four zero bits below.
// - The mux output addresses the store, which loads the pipeline.
// - Address register plus incrementer forms the microprogram counter.
// - A conditional word whose condition is low just continues.
// - A conditional word whose condition is high obeys its select.
// - Two microword bits pick which status line is tested.
// - The jump field spans the whole control store.
`include "usq_cfg.svh"

module usq_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire usq_pkg::usq_op_t instruction_data_register,
   input wire usq_pkg::usq_status_t alu_status,
   output usq_pkg::usq_ctrl_t ctrl_out,
   output usq_pkg::usq_addr_t uaddr,
   output logic running
);
   import usq_pkg::*;

   // Control store, written over APB
   usq_word_t rom [`USQ_ROM_DEPTH];

   usq_seq_if seq ();

   usq_exec u_exec (
      .seq(seq)
   );

   usq_addr_mux u_mux (
      .seq(seq)
   );

   // APB state
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   logic sel_ctrl;
   logic sel_status;
   logic sel_ptr;
   logic sel_data;
   logic sel_pipe;
   logic sel_brk;
   logic sel_cond;
   logic [31:0] rd_word;

   // Software control state
   logic run_q;
   logic step_q;
   logic brk_en_q;
   logic hit_q;
   usq_addr_t brk_q;
   usq_addr_t rom_ptr_q;
   logic next_run;
   logic next_step;
   logic next_brk_en;
   logic next_hit;
   usq_addr_t next_brk;
   usq_addr_t next_rom_ptr;
   logic rom_we;

   // Sequencer state
   usq_addr_t uaddr_q;
   usq_addr_t ret_q;
   usq_word_t pipe_q;
   usq_addr_t next_uaddr;
   usq_addr_t next_ret;
   usq_word_t next_pipe;
   logic adv;
   logic brk_now;

   // Pipeline register fields feed the execution logic
   assign seq.src_sel = usq_src_t'(pipe_q[`USQ_MW_SEL_LSB +: 2]);
   assign seq.cond_jump = pipe_q[`USQ_MW_CJ];
   assign seq.cond_sel = pipe_q[`USQ_MW_CSEL_LSB +: 2];
   assign seq.jump_addr = pipe_q[`USQ_MW_JUMP_LSB +: `USQ_AW];
   assign seq.alu_status = alu_status;
   assign seq.opcode = instruction_data_register;
   assign seq.addr_q = uaddr_q;
   assign seq.ret_q = ret_q;

   // APB decode; a transfer completes on the edge where pready_q is high
   always_comb begin
      acc = psel && penable && pready_q;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      // Full byte compare, so a stray or misaligned address is refused
      sel_ctrl = (paddr == `USQ_OFS_CTRL);
      sel_status = (paddr == `USQ_OFS_STATUS);
      sel_ptr = (paddr == `USQ_OFS_ROM_PTR);
      sel_data = (paddr == `USQ_OFS_ROM_DATA);
      sel_pipe = (paddr == `USQ_OFS_PIPE);
      sel_brk = (paddr == `USQ_OFS_BREAK);
      sel_cond = (paddr == `USQ_OFS_COND);
      mapped = sel_ctrl || sel_status || sel_ptr || sel_data || sel_pipe
         || sel_brk || sel_cond;
   end

   // Read view of every register; unmapped offsets read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_word[`USQ_CTRL_RUN] = run_q;
         rd_word[`USQ_CTRL_BRK_EN] = brk_en_q;
      end
      if (sel_status) begin
         rd_word[`USQ_ST_ADDR_LSB +: `USQ_AW] = uaddr_q;
         rd_word[`USQ_ST_RET_LSB +: `USQ_AW] = ret_q;
         rd_word[`USQ_ST_RUN] = run_q;
         rd_word[`USQ_ST_HIT] = hit_q;
      end
      if (sel_ptr) begin
         rd_word[`USQ_AW-1:0] = rom_ptr_q;
      end
      // Word at the pointer; the read steps the pointer on completion
      if (sel_data) begin
         rd_word = rom[rom_ptr_q];
      end
      if (sel_pipe) begin
         rd_word = pipe_q;
      end
      if (sel_brk) begin
         rd_word[`USQ_AW-1:0] = brk_q;
      end
      if (sel_cond) begin
         rd_word[`USQ_STW-1:0] = alu_status;
         rd_word[4] = seq.cond_value;
         rd_word[9:8] = seq.eff_sel;
      end
   end

   // Registered answer costs one wait state but keeps outputs on flops
   always_comb begin
      next_pready = psel && penable && !pready_q;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (next_pready) begin
         next_pslverr = !mapped;
         if (!pwrite) begin
            next_prdata = rd_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= next_pready;
         pslverr_q <= next_pslverr;
         prdata_q <= next_prdata;
      end
   end

   // Run, step and break enable; a breakpoint stop beats a run write
   always_comb begin
      next_run = run_q;
      next_step = 1'b0;
      next_brk_en = brk_en_q;
      if (wr && sel_ctrl) begin
         next_run = pwdata[`USQ_CTRL_RUN];
         next_step = pwdata[`USQ_CTRL_STEP];
         next_brk_en = pwdata[`USQ_CTRL_BRK_EN];
      end
      if (brk_now) begin
         next_run = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         step_q <= 1'b0;
         brk_en_q <= 1'b0;
      end else begin
         run_q <= next_run;
         step_q <= next_step;
         brk_en_q <= next_brk_en;
      end
   end

   // Break address and sticky hit; the advance that hits still happens
   always_comb begin
      brk_now = adv && brk_en_q && (seq.next_addr == brk_q);
      next_brk = brk_q;
      next_hit = hit_q;
      if (wr && sel_brk) begin
         next_brk = pwdata[`USQ_AW-1:0];
      end
      if (wr && sel_status && pwdata[`USQ_ST_HIT]) begin
         next_hit = 1'b0;
      end
      // Hardware set wins over a clear in the same cycle
      if (brk_now) begin
         next_hit = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_q <= `USQ_RST_ADDR;
         hit_q <= 1'b0;
      end else begin
         brk_q <= next_brk;
         hit_q <= next_hit;
      end
   end

   // Data port walks the store so a load is one write per word
   always_comb begin
      next_rom_ptr = rom_ptr_q;
      rom_we = 1'b0;
      if (wr && sel_ptr) begin
         next_rom_ptr = pwdata[`USQ_AW-1:0];
      end
      // Pointer wraps from the top of the store back to zero
      if ((wr || rd) && sel_data) begin
         rom_we = wr;
         next_rom_ptr = usq_addr_t'(rom_ptr_q + usq_addr_t'(1));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_ptr_q <= `USQ_RST_ADDR;
      end else begin
         rom_ptr_q <= next_rom_ptr;
      end
   end

   // Store has no reset; software must load it before running
   always_ff @(posedge pclk) begin
      if (rom_we) begin
         rom[rom_ptr_q] <= pwdata;
      end
   end

   // Sequencer advances each cycle while running, or once per step
   always_comb begin
      adv = run_q || step_q;
      next_uaddr = uaddr_q;
      next_ret = ret_q;
      next_pipe = pipe_q;
      if (adv) begin
         next_uaddr = seq.next_addr;
         next_pipe = rom[seq.next_addr];
         if (seq.call_taken) begin
            next_ret = seq.incr;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uaddr_q <= `USQ_RST_ADDR;
         ret_q <= `USQ_RST_ADDR;
         pipe_q <= `USQ_RST_WORD;
      end else begin
         uaddr_q <= next_uaddr;
         ret_q <= next_ret;
         pipe_q <= next_pipe;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ctrl_out = pipe_q[`USQ_MW_CTRL_LSB +: `USQ_CW];
   assign uaddr = uaddr_q;
   assign running = run_q;
endmodule

// File: verif/usq_assertions.sv
// Purpose: Port checks for usq_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes: The store is hidden, so only bus and hold behaviour is seen.
module usq_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire usq_pkg::usq_op_t instruction_data_register,
   input wire usq_pkg::usq_status_t alu_status,
   input wire usq_pkg::usq_ctrl_t ctrl_out,
   input wire usq_pkg::usq_addr_t uaddr,
   input wire logic running
);
   import usq_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = paddr[1:0] == 2'h0 && paddr <= 8'h18;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && !pready;
   endsequence
   // Stopped and no step pending, so nothing may advance
   sequence s_quiet;
      !running && !pready ##1 !pready;
   endsequence
   chk_ready_wait: assert property (s_setup ##1 s_access |=> pready)
      else $error("no answer after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped address not refused");
   chk_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped address refused");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero while idle");
   chk_err_rdata: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("read data not zero on error");
   chk_hold_stopped: assert property (
      s_quiet |=> $stable(uaddr) && $stable(ctrl_out))
      else $error("sequencer moved while stopped");
endmodule

bind usq_top usq_checker u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .instruction_data_register, .alu_status, .ctrl_out, .uaddr, .running);

// File: verif/usq_status_src.sv
// Purpose: Stand-in for the opcode register and the ALU status lines.
// Assumes: Values change only on a load pulse, on pclk.
// Notes: Holding them steady keeps each step's inputs well defined.
module usq_status_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire usq_pkg::usq_op_t op_in,
   input wire usq_pkg::usq_status_t st_in,
   output usq_pkg::usq_op_t opcode,
   output usq_pkg::usq_status_t status
);
   import usq_pkg::*;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opcode <= 4'h0;
         status <= 4'h0;
      end else if (load) begin
         opcode <= op_in;
         status <= st_in;
      end
   end
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for usq_top.
// Assumes: Store loaded over the bus, then stepped one word at a time.
// Notes: Run mode is tried once, stopped by a break one word ahead.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import usq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, running, err;
   usq_op_t op_in = 4'h0, opcode;
   usq_status_t st_in = 4'h0, status;
   usq_ctrl_t ctrl_out;
   usq_addr_t uaddr, cur, ret, nxt;
   usq_word_t store [256];
   usq_word_t mw, w;
   integer seed = 32'h0dee68c1, n_mismatch = 0, n_checks = 0, cyc = 0, i;
   always #2.5 pclk = ~pclk;
   usq_status_src src (.pclk, .presetn, .load(ld), .op_in, .st_in,
      .opcode, .status);
   usq_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr,
      .instruction_data_register(opcode), .alu_status(status),
      .ctrl_out, .uaddr, .running);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   // Pready is judged at the rising edge, as the slave's flops see it
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic usq_addr_t next_of(usq_word_t m, usq_addr_t a,
         usq_op_t op, usq_status_t st);
      if (m[10] && !st[m[12:11]])
         return a + 8'h01;
      case (m[9:8])
         2'b00: return {op, 4'h0};
         2'b01: return m[7:0];
         2'b10: return ret;
         default: return a + 8'h01;
      endcase
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      check(uaddr, 8'h00);
      check(ctrl_out, 16'h0);
      apb(0, 8'h1C, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(0, 8'h00, 32'h0);
      check(rd, 32'h0);
      apb(1, 8'h08, 32'h0);
      // Word 0 is a plain call; word 255 continues across the wrap
      for (i = 0; i < 256; i++) begin
         w = $random(seed);
         if (i == 0)
            w[12:8] = 5'h01;
         if (i == 255)
            w[12:8] = 5'h03;
         store[i] = w;
         apb(1, 8'h0C, w);
      end
      mw = 32'h0;
      cur = 8'h00;
      ret = 8'h00;
      for (i = 0; i < 300; i++) begin
         @(posedge pclk);
         ld <= 1'b1;
         op_in <= (i == 0) ? 4'h0 : 4'($random(seed));
         st_in <= 4'($random(seed));
         @(posedge pclk);
         ld <= 1'b0;
         apb(1, 8'h00, 32'h2);
         nxt = next_of(mw, cur, op_in, st_in);
         if (mw[9:8] == 2'b01 && !(mw[10] && !st_in[mw[12:11]]))
            ret = cur + 8'h01;
         repeat (3) @(posedge pclk);
         check(uaddr, nxt);
         check(ctrl_out, store[nxt][31:16]);
         check(running, 1'b0);
         apb(0, 8'h04, 32'h0);
         check(rd[15:0], {ret, nxt});
         apb(0, 8'h10, 32'h0);
         check(rd, store[nxt]);
         mw = store[nxt];
         cur = nxt;
         apb(0, 8'h18, 32'h0);
         check(rd[4:0], {st_in[mw[12:11]], st_in});
         check(rd[9:8], (mw[10] && !st_in[mw[12:11]]) ? 2'b11 : mw[9:8]);
      end
      // Run with a breakpoint on the very next address: one advance only
      nxt = next_of(mw, cur, op_in, st_in);
      apb(1, 8'h14, {24'h0, nxt});
      apb(1, 8'h00, 32'h5);
      repeat (3) @(posedge pclk);
      check(uaddr, nxt);
      check(ctrl_out, store[nxt][31:16]);
      check(running, 1'b0);
      apb(0, 8'h04, 32'h0);
      check(rd[17:16], 2'b10);
      apb(1, 8'h04, 32'h0002_0000);
      apb(0, 8'h04, 32'h0);
      check(rd[17:16], 2'b00);
      // Reset after the breakpoint stop brings every register back
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check(uaddr, 8'h00);
      check(ctrl_out, 16'h0);
      check(running, 1'b0);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h0);
      tally_and_finish;
   end
endmodule
